// >>> common/mbp_pkg.sv
// Purpose: constants and types of the message buffer port
// Assumes: byte-wide register map reached over a two-wire serial slave
// Notes:   shared by the core and the buffer memory
// Overview of operation
// - first written byte after the slave address loads the pointer
// - further written bytes go to the pointed register, pointer advances
// - reads start at the pointed register, pointer advances per byte
// - reads past 19h or past the frame length return FFh
// - pointer 00h never advances, so status can be polled
// - a frame length below 3 marks the frame invalid
// - a frame written short is discarded with no confirmation
// - surplus bytes after the counted length are ignored, frame processed
// - frames longer than the bank are processed at the last register
// - the bank holds a valid message only while the interrupt is set
// - with no interrupt, 07h reads 0 and later bytes read FFh
// - a read right after a data write starts at 07h
// - a message read only partly is discarded, interrupt dropped
// - reading the last valid byte drops the interrupt
// - masks 00h and 08h acknowledge logical address 3 only
// - a ready response sets the interrupt line and status bit 6
// - second frame byte is the service code
// - a confirmation carries one result byte
// - the data bank spans 07h to 19h, read and write
// - only one transmit request may be outstanding
package mbp_pkg;
   localparam logic [7:0] OFS_STATUS    = 8'h00;
   localparam logic [7:0] OFS_CTRL      = 8'h03;
   localparam logic [7:0] OFS_ACK_MASK_HIGH      = 8'h04;
   localparam logic [7:0] OFS_ACK_MASK_LOW      = 8'h05;
   localparam logic [7:0] OFS_BUF_FIRST = 8'h07;
   localparam logic [7:0] OFS_BUF_LAST  = 8'h19;
   localparam int         BUF_DEPTH     = 19;
   localparam logic [4:0] BUF_LAST_IDX  = 5'h12;
   localparam logic [7:0] FILL_BYTE     = 8'hff;
   localparam logic [7:0] EMPTY_BYTE    = 8'h00;
   localparam logic [7:0] MIN_FRAME     = 8'h03;
   localparam logic [7:0] CNF_LEN       = 8'h03;
   localparam logic [7:0] RST_REG       = 8'h00;
   localparam int         CTRL_ON_BIT   = 6;
   // service codes
   localparam logic [7:0] SVC_TX_REQ    = 8'h00;
   localparam logic [7:0] SVC_TX_CNF    = 8'h01;
   localparam logic [7:0] SVC_RX_IND    = 8'h81;
   localparam logic [7:0] SVC_ERR       = 8'h82;
   localparam logic [7:0] SVC_RX_ERR    = 8'h83;
   // result bytes; 80h and 81h made here, 00h and line failures 82h..86h come from the link
   localparam logic [7:0] RES_OK        = 8'h00;
   localparam logic [7:0] RES_OFF       = 8'h80;
   localparam logic [7:0] RES_BAD_REQ   = 8'h81;
   localparam logic [3:0] BITS_BYTE     = 4'h8;

   typedef enum logic [2:0] {
      I_IDLE = 3'b000,
      I_ADDR = 3'b001,
      I_AACK = 3'b010,
      I_WR   = 3'b011,
      I_WACK = 3'b100,
      I_RD   = 3'b101,
      I_RACK = 3'b110
   } mbp_i2c_e;
endpackage : mbp_pkg

// >>> common/mbp_mem_if.sv
// Purpose: carrier between the core and the message buffer memory
// Assumes: one write port and one registered read port
// Notes:   core drives the addresses, memory returns read data
`timescale 1ns/100ps
interface mbp_mem_if;
   logic       we;
   logic [4:0] waddr;
   logic [7:0] wdata;
   logic [4:0] raddr;
   logic [7:0] rdata;
   modport core  (output we, output waddr, output wdata, output raddr,
                  input rdata);
   modport store (input we, input waddr, input wdata, input raddr,
                  output rdata);
endinterface : mbp_mem_if

// >>> verilog/mbp_buf_mem.sv
// Purpose: storage for the message data bank
// Assumes: read address settles long before data is used
// Notes:   read data comes out of a register, one cycle late
`timescale 1ns/100ps
module mbp_buf_mem
   import mbp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   mbp_mem_if.store mp
);
   logic [7:0] mem_q [BUF_DEPTH];
   logic [7:0] rd_q;

   // write port, no reset needed for the array
   always_ff @(posedge clk) begin
      if (mp.we) begin
         mem_q[mp.waddr] <= mp.wdata;
      end
   end

   // registered read, out of range reads as fill
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_q <= RST_REG;
      end else if (mp.raddr <= BUF_LAST_IDX) begin
         rd_q <= mem_q[mp.raddr];
      end else begin
         rd_q <= FILL_BYTE;
      end
   end

   assign mp.rdata = rd_q;
endmodule : mbp_buf_mem

// >>> verilog/mbp_top.sv
// Purpose: serial register port with message bank and link handshake
// Assumes: scl/sda oversampled on clk; link side on its own clock
// Notes:   only confirmations are posted back; line engine is outside
`timescale 1ns/100ps
module mbp_top
   import mbp_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = 7'h34 // value is arbitrary
)(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   output logic             msg_irq,
   input  wire logic        link_clk,
   input  wire logic        link_done,
   input  wire logic [7:0]  link_result,
   output logic             link_req,
   output logic [7:0]       link_req_len,
   output logic [7:0]       link_req_addr,
   output logic             link_on,
   output logic [15:0]      link_ack_map
);
   typedef struct packed {
      logic       scl_m, scl_s, scl_p;
      logic       sda_m, sda_s, sda_p;
      mbp_i2c_e   st;
      logic [3:0] bitc;
      logic [7:0] shf, rdb, ptr;
      logic       rw, first, oe, sdo;
      logic [7:0] ctl, ack_mask_high, ack_mask_low;
      logic       busy, intr;
      logic [7:0] rlen;
      logic       wact;
      logic [7:0] wlen, svc, addr;
      logic       wrote, rd_any, req;
      logic [7:0] qlen, qaddr;
      logic       rs_m, rs_s, ack;
      logic [1:0] post;
      logic [7:0] res;
   } mbp_core_s;

   typedef struct packed {
      logic        rq_m, rq_s, req;
      logic [7:0]  len, addr;
      logic        on_m, on_s;
      logic [15:0] map_m, map_s;
      logic        rsp;
      logic [7:0]  res;
      logic        ak_m, ak_s;
   } mbp_link_s;

   mbp_core_s  r_q, r_d;
   mbp_link_s  l_q, l_d;
   logic [1:0] rsy_q, lrsy_q;
   logic       rst_n, lrst_n;
   logic       scl_r, scl_f, start, stop, byte_in;
   logic       ld, acc, dw0;
   logic [7:0] tx_b;
   logic [4:0] idx;

   mbp_mem_if mif ();

   mbp_buf_mem u_mem (
      .clk   (clk),
      .rst_n (rst_n),
      .mp    (mif.store)
   );

   function automatic logic is_buf(input logic [7:0] p);
      return (p >= OFS_BUF_FIRST) && (p <= OFS_BUF_LAST);
   endfunction : is_buf

   function automatic logic [4:0] buf_idx(input logic [7:0] p);
      logic [7:0] d;
      d = p - OFS_BUF_FIRST;
      return d[4:0];
   endfunction : buf_idx

   function automatic logic [7:0] ptr_next(input logic [7:0] p);
      return (p == OFS_STATUS) ? OFS_STATUS : p + 8'h01;
   endfunction : ptr_next

   // reset release, one copy per domain
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rsy_q <= 2'b00;
      end else begin
         rsy_q <= {rsy_q[0], 1'b1};
      end
   end
   always_ff @(posedge link_clk or negedge arst_n) begin
      if (!arst_n) begin
         lrsy_q <= 2'b00;
      end else begin
         lrsy_q <= {lrsy_q[0], 1'b1};
      end
   end
   assign rst_n  = rsy_q[1];
   assign lrst_n = lrsy_q[1];

   // bus conditions from synchronised pins
   assign scl_r   = r_q.scl_s & ~r_q.scl_p;
   assign scl_f   = ~r_q.scl_s & r_q.scl_p;
   assign start   = r_q.scl_s & r_q.scl_p & r_q.sda_p & ~r_q.sda_s;
   assign stop    = r_q.scl_s & r_q.scl_p & ~r_q.sda_p & r_q.sda_s;
   assign byte_in = (r_q.st == I_WR) && scl_f && (r_q.bitc == BITS_BYTE)
                    && !start && !stop;
   assign idx       = buf_idx(r_q.ptr);
   assign mif.raddr = idx;

   // core next state
   always_comb begin
      r_d       = r_q;
      mif.we    = 1'b0;
      mif.waddr = idx;
      mif.wdata = r_q.shf;
      ld        = 1'b0;
      acc       = 1'b0;
      dw0       = 1'b0;
      r_d.scl_m = scl_i;
      r_d.scl_s = r_q.scl_m;
      r_d.scl_p = r_q.scl_s;
      r_d.sda_m = sda_i;
      r_d.sda_s = r_q.sda_m;
      r_d.sda_p = r_q.sda_s;
      r_d.sdo   = 1'b0;
      r_d.rs_m  = l_q.rsp;
      r_d.rs_s  = r_q.rs_m;

      // byte the host would read at the pointer
      if (r_q.ptr == OFS_STATUS) begin
         tx_b = {r_q.busy, r_q.intr, 6'h00};
      end else if (r_q.ptr == OFS_CTRL) begin
         tx_b = r_q.ctl;
      end else if (r_q.ptr == OFS_ACK_MASK_HIGH) begin
         tx_b = r_q.ack_mask_high;
      end else if (r_q.ptr == OFS_ACK_MASK_LOW) begin
         tx_b = r_q.ack_mask_low;
      end else if (is_buf(r_q.ptr)) begin
         if (!r_q.intr) begin
            tx_b = (r_q.ptr == OFS_BUF_FIRST) ? EMPTY_BYTE : FILL_BYTE;
         end else if ({3'h0, idx} < r_q.rlen) begin
            tx_b = mif.rdata;
         end else begin
            tx_b = FILL_BYTE;
         end
      end else if (r_q.ptr > OFS_BUF_LAST) begin
         tx_b = FILL_BYTE;
      end else begin
         tx_b = 8'h00;
      end

      // serial slave; start/stop end any transfer at once
      if (start || stop) begin
         r_d.st   = start ? I_ADDR : I_IDLE;
         r_d.bitc = 4'h0;
         r_d.oe   = 1'b0;
         r_d.wact = 1'b0;
         if (r_q.rd_any) begin
            r_d.intr   = 1'b0;
            r_d.rd_any = 1'b0;
         end
      end else begin
         case (r_q.st)
            I_ADDR: begin
               if (scl_r) begin
                  r_d.shf  = {r_q.shf[6:0], r_q.sda_s};
                  r_d.bitc = r_q.bitc + 4'h1;
               end else if (scl_f && r_q.bitc == BITS_BYTE) begin
                  if (r_q.shf[7:1] == SLAVE_ADDR) begin
                     r_d.rw    = r_q.shf[0];
                     r_d.first = ~r_q.shf[0];
                     r_d.oe    = 1'b1;
                     r_d.st    = I_AACK;
                     if (r_q.shf[0] && r_q.wrote) begin
                        r_d.ptr   = OFS_BUF_FIRST;
                        r_d.wrote = 1'b0;
                     end
                  end else begin
                     r_d.st = I_IDLE;
                  end
               end
            end
            I_AACK: begin
               if (scl_f) begin
                  r_d.bitc = 4'h0;
                  r_d.oe   = 1'b0;
                  r_d.st   = I_WR;
                  ld       = r_q.rw;
               end
            end
            I_WR: begin
               if (scl_r) begin
                  r_d.shf  = {r_q.shf[6:0], r_q.sda_s};
                  r_d.bitc = r_q.bitc + 4'h1;
               end else if (byte_in) begin
                  r_d.oe = 1'b1;
                  r_d.st = I_WACK;
                  if (r_q.first) begin
                     r_d.ptr   = r_q.shf;
                     r_d.first = 1'b0;
                     r_d.wrote = 1'b0;
                  end else begin
                     r_d.ptr = ptr_next(r_q.ptr);
                     if (r_q.ptr == OFS_CTRL) begin
                        r_d.ctl = r_q.shf;
                     end else if (r_q.ptr == OFS_ACK_MASK_HIGH) begin
                        r_d.ack_mask_high = r_q.shf;
                     end else if (r_q.ptr == OFS_ACK_MASK_LOW) begin
                        r_d.ack_mask_low = r_q.shf;
                     end else if (is_buf(r_q.ptr) && !r_q.busy) begin
                        r_d.wrote = 1'b1;
                        if (idx == 5'h00) begin
                           dw0       = 1'b1;
                           mif.we    = 1'b1;
                           r_d.wlen  = r_q.shf;
                           r_d.wact  = (r_q.shf >= MIN_FRAME);
                        end else if (r_q.wact) begin
                           mif.we = 1'b1;
                           if (idx == 5'h01) begin
                              r_d.svc = r_q.shf;
                           end
                           if (idx == 5'h02) begin
                              r_d.addr = r_q.shf;
                           end
                           // frame ends at its count or at the top
                           if ({3'h0, idx} == r_q.wlen - 8'h01 ||
                               idx == BUF_LAST_IDX) begin
                              acc      = 1'b1;
                              r_d.wact = 1'b0;
                              r_d.busy = 1'b1;
                              if (!r_q.ctl[CTRL_ON_BIT]) begin
                                 r_d.post = 2'b01;
                                 r_d.res  = RES_OFF;
                              end else if (r_q.svc != SVC_TX_REQ) begin
                                 r_d.post = 2'b01;
                                 r_d.res  = RES_BAD_REQ;
                              end else begin
                                 r_d.req   = 1'b1;
                                 r_d.qlen  = r_q.wlen;
                                 r_d.qaddr = r_d.addr;
                              end
                           end
                        end
                     end
                  end
               end
            end
            I_WACK: begin
               if (scl_f) begin
                  r_d.oe   = 1'b0;
                  r_d.bitc = 4'h0;
                  r_d.st   = I_WR;
               end
            end
            I_RD: begin
               if (scl_r) begin
                  r_d.bitc = r_q.bitc + 4'h1;
               end else if (scl_f) begin
                  if (r_q.bitc == BITS_BYTE) begin
                     r_d.oe = 1'b0;
                     r_d.st = I_RACK;
                  end else begin
                     r_d.rdb = {r_q.rdb[6:0], 1'b1};
                     r_d.oe  = ~r_q.rdb[6];
                  end
               end
            end
            I_RACK: begin
               if (scl_r) begin
                  r_d.shf[0] = r_q.sda_s;
               end else if (scl_f) begin
                  // a not-acknowledge ends the read; stop cleans up
                  ld       = ~r_q.shf[0];
                  r_d.st   = r_q.shf[0] ? I_IDLE : I_WR;
               end
            end
            default: begin
               r_d.st = I_IDLE;
            end
         endcase
      end

      // load one byte for the master, pointer moves on
      if (ld) begin
         r_d.st   = I_RD;
         r_d.bitc = 4'h0;
         r_d.rdb  = tx_b;
         r_d.oe   = ~tx_b[7];
         r_d.ptr  = ptr_next(r_q.ptr);
         if (is_buf(r_q.ptr) && r_q.intr && {3'h0, idx} < r_q.rlen) begin
            r_d.rd_any = 1'b1;
            if ({3'h0, idx} == r_q.rlen - 8'h01) begin
               r_d.intr   = 1'b0;
               r_d.rd_any = 1'b0;
            end
         end
      end

      // link answer: four-phase handshake, result held by link side
      if (r_q.ack && !r_q.rs_s) begin
         r_d.ack = 1'b0;
      end else if (r_q.rs_s && !r_q.ack && r_q.req) begin
         r_d.ack  = 1'b1;
         r_d.req  = 1'b0;
         r_d.post = 2'b01;
         r_d.res  = l_q.res;
      end

      // post a confirmation frame, three bytes, then raise interrupt
      if (r_q.post != 2'b00) begin
         mif.we    = 1'b1;
         mif.waddr = {3'h0, r_q.post - 2'b01};
         mif.wdata = (r_q.post == 2'b01) ? CNF_LEN :
                     (r_q.post == 2'b10) ? SVC_TX_CNF : r_q.res;
         r_d.post  = r_q.post + 2'b01;
         if (r_q.post == 2'b11) begin
            r_d.intr = 1'b1;
            r_d.busy = 1'b0;
            r_d.rlen = CNF_LEN;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_q       <= '0;
         r_q.st    <= I_IDLE;
         r_q.ctl   <= RST_REG;
         // pins idle high; a zero here would fake an scl edge
         r_q.scl_m <= 1'b1;
         r_q.scl_s <= 1'b1;
         r_q.scl_p <= 1'b1;
         r_q.sda_m <= 1'b1;
         r_q.sda_s <= 1'b1;
         r_q.sda_p <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   // link side: requests and config cross in, result handshake out
   always_comb begin
      l_d       = l_q;
      l_d.rq_m  = r_q.req;
      l_d.rq_s  = l_q.rq_m;
      l_d.req   = l_q.rq_s;
      l_d.on_m  = r_q.ctl[CTRL_ON_BIT];
      l_d.on_s  = l_q.on_m;
      // config is quasi-static, so a per-bit two-flop pass is enough
      l_d.map_m = {r_q.ack_mask_high, r_q.ack_mask_low};
      l_d.map_s = l_q.map_m;
      l_d.ak_m  = r_q.ack;
      l_d.ak_s  = l_q.ak_m;
      if (l_q.rq_s && !l_q.req) begin
         l_d.len  = r_q.qlen;
         l_d.addr = r_q.qaddr;
      end
      if (l_q.rsp && l_q.ak_s) begin
         l_d.rsp = 1'b0;
      end else if (link_done && l_q.req && !l_q.rsp && !l_q.ak_s) begin
         l_d.rsp = 1'b1;
         l_d.res = link_result;
      end
   end

   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         l_q <= '0;
      end else begin
         l_q <= l_d;
      end
   end

   assign sda_o         = r_q.sdo;
   assign sda_oe        = r_q.oe;
   assign msg_irq       = r_q.intr;
   assign link_req      = l_q.req;
   assign link_req_len  = l_q.len;
   assign link_req_addr = l_q.addr;
   assign link_on       = l_q.on_s;
   assign link_ack_map  = l_q.map_s;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_post_run;
      r_q.post == 2'b01 ##1 r_q.post == 2'b10 ##1 r_q.post == 2'b11;
   endsequence

   a_post_order: assert property (
      $rose(r_q.post != 2'b00) |-> s_post_run ##1 (r_q.intr && !r_q.busy))
      else $error("confirmation post out of order");
   a_ptr_zero: assert property (
      r_q.ptr == OFS_STATUS && !(byte_in && r_q.first) && !r_q.wrote
      |=> r_q.ptr == OFS_STATUS)
      else $error("pointer left zero");
   a_wr_advance: assert property (
      byte_in && !r_q.first && r_q.ptr != OFS_STATUS
      |=> r_q.ptr == $past(r_q.ptr) + 8'h01)
      else $error("pointer did not advance on write");
   a_fill_high: assert property (
      ld && r_q.ptr > OFS_BUF_LAST |-> tx_b == FILL_BYTE)
      else $error("no fill byte past bank");
   a_empty_first: assert property (
      ld && !r_q.intr && r_q.ptr == OFS_BUF_FIRST |-> tx_b == EMPTY_BYTE)
      else $error("empty bank first byte not zero");
   a_int_last: assert property (
      ld && r_q.intr && is_buf(r_q.ptr) && {3'h0, idx} == r_q.rlen - 8'h01
      |=> !r_q.intr)
      else $error("interrupt kept after last byte");
   a_short_drop: assert property (
      dw0 && r_q.shf < MIN_FRAME |=> !r_q.wact)
      else $error("short frame kept");
   a_accept_once: assert property (
      acc |-> !r_q.busy ##1 r_q.busy)
      else $error("request accepted while busy");
   a_busy_block: assert property (
      byte_in && r_q.busy && !r_q.first && r_q.post == 2'b00
      |-> !mif.we)
      else $error("bank written while busy");
   a_early_stop: assert property (
      (start || stop) && r_q.rd_any && r_q.post != 2'b11 |=> !r_q.intr)
      else $error("partly read message kept");
   a_rd_restart: assert property (
      r_q.st == I_ADDR && scl_f && r_q.bitc == BITS_BYTE && !start &&
      !stop && r_q.shf == {SLAVE_ADDR, 1'b1} && r_q.wrote
      |=> r_q.ptr == OFS_BUF_FIRST)
      else $error("read after write not at bank start");
endmodule : mbp_top

// >>> tb/mbp_host_model.sv
// Purpose: serial bus master standing in for the host processor
// Assumes: open-drain lines; the bench resolves the wire level
// Notes:   quarter bit of 5 clk keeps scl low well above 4 clk
`timescale 1ns/100ps
module mbp_host_model
   import mbp_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h34 // value is arbitrary
)(
   input  wire logic clk,
   input  wire logic sda_in,
   output logic      scl,
   output logic      sda_low
);
   // bus idles released
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end
   // every change lands 1 ns after a core edge
   task automatic tk();
      repeat (5) @(posedge clk);
      #1;
   endtask : tk
   // one bit each way, sampled in the high phase
   task automatic bit_io(input logic b, output logic s);
      sda_low = ~b;
      tk();
      scl = 1'b1;
      tk();
      s = sda_in;
      tk();
      scl = 1'b0;
      tk();
   endtask : bit_io
   task automatic xfer(input logic [7:0] w, input logic a,
                       output logic [7:0] r);
      logic k;
      for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
      bit_io(a, k);
   endtask : xfer
   task automatic start();
      sda_low = 1'b0;
      tk();
      scl = 1'b1;
      tk();
      sda_low = 1'b1;
      tk();
      scl = 1'b0;
      tk();
   endtask : start
   task automatic stop();
      sda_low = 1'b1;
      tk();
      scl = 1'b1;
      tk();
      sda_low = 1'b0;
      tk();
   endtask : stop
   // pointer byte first; one transaction per range
   task automatic wr(input logic [7:0] q[$]);
      logic [7:0] r;
      start();
      xfer({DEV_ADDR, 1'b0}, 1'b1, r);
      foreach (q[i]) xfer(q[i], 1'b1, r);
      stop();
   endtask : wr
   // nack on the last byte ends the read
   task automatic rd(input int n, output logic [7:0] q[$]);
      logic [7:0] r;
      q = {};
      start();
      xfer({DEV_ADDR, 1'b1}, 1'b1, r);
      for (int i = 0; i < n; i++) begin
         xfer(8'hff, i == n - 1, r);
         q.push_back(r);
      end
      stop();
   endtask : rd
endmodule : mbp_host_model

// >>> tb/tb_mbp_top.sv
// Purpose: self-checking bench of the message buffer port
// Assumes: host model on the serial pins, bench answers the link
// Notes:   sda is pulled up, so released means 1
`timescale 1ns/100ps
module tb_mbp_top;
   import mbp_pkg::*;
   logic       clk, arst_n, link_clk, link_done, scl, sda_low;
   logic [7:0] link_result;
   logic       sda_o, sda_oe, msg_irq, link_req, link_on;
   logic [7:0] link_req_len, link_req_addr;
   logic [15:0] link_ack_map;
   int         fail_count, samples_checked;
   wire        sda_w = ~(sda_low | (sda_oe & ~sda_o));
   // clocks of unrelated phase
   always #20 clk = ~clk;
   always #3 link_clk = ~link_clk;
   mbp_top mbp_top_inst (.clk(clk), .arst_n(arst_n), .scl_i(scl),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .msg_irq(msg_irq),
      .link_clk(link_clk), .link_done(link_done),
      .link_result(link_result), .link_req(link_req),
      .link_req_len(link_req_len), .link_req_addr(link_req_addr),
      .link_on(link_on), .link_ack_map(link_ack_map));
   mbp_host_model mbp_host_model_inst (.clk(clk), .sda_in(sda_w),
      .scl(scl), .sda_low(sda_low));
   task automatic chk(input string nm, input logic [23:0] s, e);
      samples_checked++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic final_report();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report
   task automatic wait_irq();
      for (int i = 0; i < 3000 && msg_irq !== 1'b1; i++) @(posedge clk);
      #1;
   endtask : wait_irq
   // two status reads at pointer 00h must agree
   task automatic st(output logic [7:0] s);
      logic [7:0] q[$];
      mbp_host_model_inst.wr('{OFS_STATUS});
      mbp_host_model_inst.rd(2, q);
      chk("poll", q[1], q[0]);
      s = q[0];
   endtask : st
   task automatic link_answer(input logic [7:0] res);
      @(posedge link_clk);
      #1;
      link_result = res;
      link_done   = 1'b1;
      @(posedge link_clk);
      #1;
      link_done = 1'b0;
   endtask : link_answer
   // one frame out, confirmation read back in full
   task automatic tx(input logic [7:0] len, input int n,
                     input logic [7:0] sv, input logic lk,
                     input logic [7:0] res);
      logic [7:0] q[$];
      logic [7:0] s;
      q = '{OFS_BUF_FIRST, len, sv, 8'h40};
      while (q.size() <= n) q.push_back(8'h0d);
      mbp_host_model_inst.wr(q);
      if (lk) begin
         mbp_host_model_inst.rd(2, q);
         chk("empty bank", {q[0], q[1]}, 16'h00ff);
         st(s);
         chk("busy", s[7:6], 2'b10);
         chk("req", {link_req, link_req_addr}, 9'h140);
         if (len < 8'h14) chk("req_len", link_req_len, len);
         // a bad frame taken while busy would post at once
         mbp_host_model_inst.wr('{OFS_BUF_FIRST, 8'h03, 8'h55, 8'h50});
         chk("one req", {msg_irq, link_req_addr}, 9'h040);
         link_answer(res);
      end
      wait_irq();
      st(s);
      chk("ready", {msg_irq, s[7:6]}, 3'b101);
      mbp_host_model_inst.wr('{OFS_BUF_FIRST});
      mbp_host_model_inst.rd(4, q);
      chk("cnf", {q[0], q[1]}, {CNF_LEN, SVC_TX_CNF});
      chk("result", {q[2], q[3]}, {res, FILL_BYTE});
      chk("irq drop", msg_irq, 1'b0);
   endtask : tx
   // masks then control; read back across the gap
   task automatic init_dev();
      logic [7:0] q[$];
      mbp_host_model_inst.wr('{OFS_ACK_MASK_HIGH, 8'h00, 8'h08});
      mbp_host_model_inst.wr('{OFS_CTRL, 8'h40});
      repeat (10) @(posedge clk);
      chk("ack map", {link_on, link_ack_map}, 17'h10008);
      mbp_host_model_inst.wr('{OFS_CTRL});
      mbp_host_model_inst.rd(4, q);
      chk("regs", {q[0], q[1], q[2]}, 24'h400008);
      chk("gap", q[3], RST_REG);
   endtask : init_dev
   // short and invalid frames leave no trace
   task automatic short_frames();
      logic [7:0] s;
      logic [7:0] q[$];
      mbp_host_model_inst.wr('{OFS_BUF_FIRST, 8'h05, 8'h00, 8'h40});
      mbp_host_model_inst.wr('{OFS_BUF_FIRST, 8'h02, 8'h00, 8'h40, 8'h0d});
      repeat (200) @(posedge clk);
      st(s);
      chk("no req", {msg_irq, link_req, s[7:6]}, 4'h0);
      mbp_host_model_inst.wr('{OFS_BUF_LAST});
      mbp_host_model_inst.rd(2, q);
      chk("past bank", {q[0], q[1]}, 16'hffff);
   endtask : short_frames
   task automatic partial_read();
      logic [7:0] q[$];
      mbp_host_model_inst.wr('{OFS_BUF_FIRST, 8'h03, 8'h55, 8'h40});
      wait_irq();
      mbp_host_model_inst.wr('{OFS_BUF_FIRST});
      mbp_host_model_inst.rd(2, q);
      chk("part", {q[0], q[1], msg_irq}, {CNF_LEN, SVC_TX_CNF, 1'b0});
      mbp_host_model_inst.wr('{OFS_BUF_FIRST});
      mbp_host_model_inst.rd(1, q);
      chk("gone", q[0], EMPTY_BYTE);
   endtask : partial_read
   // reset for 4 clk, then every scenario in turn
   initial begin
      clk             = 1'b0;
      link_clk        = 1'b0;
      arst_n          = 1'b0;
      link_done       = 1'b0;
      link_result     = 8'h00;
      fail_count      = 0;
      samples_checked = 0;
      repeat (4) @(posedge clk);
      #1;
      arst_n = 1'b1;
      repeat (5) @(posedge clk);
      tx(8'h04, 4, SVC_TX_REQ, 1'b0, RES_OFF);
      init_dev();
      tx(8'h04, 4, SVC_TX_REQ, 1'b1, RES_OK);
      tx(8'h03, 6, SVC_TX_REQ, 1'b1, RES_OK);
      tx(8'h20, 19, SVC_TX_REQ, 1'b1, RES_OK);
      tx(8'h04, 4, SVC_ERR, 1'b0, RES_BAD_REQ);
      for (int c = 8'h82; c <= 8'h86; c++)
         tx(8'h03, 3, SVC_TX_REQ, 1'b1, c[7:0]);
      short_frames();
      partial_read();
      final_report();
   end
   // the run needs about 65k clk; cut off at 90k
   initial begin
      #3600000;
      fail_count++;
      final_report();
   end
endmodule : tb_mbp_top
